// [hdl/idaq_regs.sv]
/*
  Register decoder of an ISA data acquisition card: 16 byte locations with
  three interval counters, A/D result and pending flag, two D/A channels,
  16 digital inputs and outputs, interrupt clear and conversion triggers.
  Assumes the host I/O strobes, address and pins are asynchronous and are
  synchronised here; the A/D converter is outside and returns a done pulse.
*/
//
// Function
// - Decode 16 consecutive I/O byte addresses above a selectable base.
// - Offsets 0-2 reach counters; offset 3 takes the control word, reads unused.
// - Reads at 4-7 give result and inputs; writes there load D/A.
// - Offsets 9-14 are write only; offset 15 does nothing.
// - Result low byte reads at offset 4, high byte at offset 5.
// - Result is passed as two's complement, unchanged.
// - Result bit 15 is MSB, bit 0 LSB, in byte order.
// - Offset 8 bit 5 is pending flag: 1 not ready, 0 done.
// - Reading the low result byte sets the pending flag again.
// - Interrupt drives one selectable line, line 15 by default.
// - Counter 0 clocked by pin; counters 1,2 share gate; outputs on pins.
// - 16 latched outputs from offsets 13,14; inputs read at 6,7.
// - External trigger pin can start a conversion.
// - Write to 8 clears interrupt status; write to 12 starts conversion when mode is MODE_RESET and the external trigger is not selected.
// - Counter 2 from 2 MHz on-board clock; counter 1 from counter 2 output.
`timescale 1ns/1ps
module idaq_regs #(
  parameter logic [idaq_pkg::BASE_W-1:0] BASE_SEL = idaq_pkg::BASE_DEFAULT,
  parameter int IRQ_SEL = idaq_pkg::IRQ_DEFAULT
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Host I/O bus
  input wire logic [idaq_pkg::IO_ADDR_W-1:0] i_io_addr,
  input wire logic i_ior_n,
  input wire logic i_iow_n,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_io_rdata_oe,
  output logic [idaq_pkg::IRQ_W-1:0] o_irq,
  // Converter side
  input wire logic [15:0] i_conversion_result_bits,
  input wire logic i_conversion_done,
  output logic o_convert_start,
  output logic [idaq_pkg::RANGE_W-1:0] o_range,
  output logic [idaq_pkg::CHAN_W-1:0] o_channel,
  output logic [idaq_pkg::MODE_W-1:0] o_mode,
  output logic [idaq_pkg::DAC_W-1:0] o_dac1,
  output logic [idaq_pkg::DAC_W-1:0] o_dac2,
  // Pins
  input wire logic [15:0] i_digital_input_line,
  output logic [15:0] o_digital_output_line,
  input wire logic i_external_convert_trigger,
  input wire logic i_external_pacer_clock,
  input wire logic i_counter_gate,
  input wire logic i_ext_trigger_select,
  output logic [2:0] o_counter_output_pin
);
  localparam int CW = idaq_pkg::CNT_W;

  // Synchronised pins
  logic [1:0] strobe_s;
  logic [15:0] din_s;
  logic [3:0] pin_s;
  logic [idaq_pkg::IO_ADDR_W+idaq_pkg::DATA_W-1:0] bus_s;
  logic ior_q_ff;
  logic iow_q_ff;
  logic ext_trig_q_ff;
  logic ext_clk_q_ff;
  logic c2_out_q_ff;
  logic [idaq_pkg::ADDR_W-1:0] ofs_ff;
  logic hit_ff;
  logic [7:0] wdata_ff;
  logic pending_ff;
  logic irq_flag_ff;
  logic [15:0] result_ff;
  logic [7:0] rdata_ff;
  logic rd_oe_ff;
  logic [15:0] dout_ff;
  logic [idaq_pkg::DAC_W-1:0] dac1_ff;
  logic [idaq_pkg::DAC_W-1:0] dac2_ff;
  logic [7:0] dac1_lo_ff;
  logic [7:0] dac2_lo_ff;
  logic [idaq_pkg::RANGE_W-1:0] range_ff;
  logic [idaq_pkg::CHAN_W-1:0] chan_ff;
  logic [idaq_pkg::MODE_W-1:0] mode_ff;
  logic start_ff;
  logic [$clog2(idaq_pkg::PACER_DIV)-1:0] osc_ff;
  logic [7:0] cnt_rdata [3];
  logic [2:0] cnt_out;
  logic [2:0] cnt_tick;
  logic [2:0] cnt_gate;

  idaq_sync #(.W(2)) u_sync_strobe (
    .i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_async({~i_ior_n, ~i_iow_n}), .o_sync(strobe_s)
  );
  idaq_sync #(.W(16)) u_sync_din (
    .i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_async(i_digital_input_line), .o_sync(din_s)
  );
  idaq_sync #(.W(4)) u_sync_pin (
    .i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_async({i_external_convert_trigger, i_external_pacer_clock, i_counter_gate, i_ext_trigger_select}),
    .o_sync(pin_s)
  );
  idaq_sync #(.W(idaq_pkg::IO_ADDR_W + idaq_pkg::DATA_W)) u_sync_bus (
    .i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_async({i_io_addr, i_io_wdata}), .o_sync(bus_s)
  );

  // Strobe edges and address decode
  wire logic rd_rise = strobe_s[1] && !ior_q_ff;
  wire logic wr_rise = strobe_s[0] && !iow_q_ff;
  wire logic rd_fall = !strobe_s[1] && ior_q_ff;
  wire logic [idaq_pkg::IO_ADDR_W-1:0] addr_s = bus_s[idaq_pkg::IO_ADDR_W+idaq_pkg::DATA_W-1:idaq_pkg::DATA_W];
  wire logic [idaq_pkg::DATA_W-1:0] wdata_s = bus_s[idaq_pkg::DATA_W-1:0];
  wire logic base_hit = (addr_s[idaq_pkg::IO_ADDR_W-1:idaq_pkg::ADDR_W] == BASE_SEL);
  wire logic rd_evt = rd_rise && hit_ff;
  wire logic wr_evt = wr_rise && hit_ff;
  wire logic ext_trig_rise = pin_s[3] && !ext_trig_q_ff;
  wire logic ext_clk_rise = pin_s[2] && !ext_clk_q_ff;
  wire logic gate_s = pin_s[1];
  wire logic ext_sel = pin_s[0];

  wire logic [2:0] cnt_sel = {ofs_ff == idaq_pkg::OFS_CNT2, ofs_ff == idaq_pkg::OFS_CNT1,
    ofs_ff == idaq_pkg::OFS_CNT0};
  wire logic [2:0] cnt_wr = {3{wr_evt}} & cnt_sel;
  wire logic [2:0] cnt_rd = {3{rd_evt}} & cnt_sel;
  wire logic wr_ctrl = wr_evt && (ofs_ff == idaq_pkg::OFS_CTRL);
  wire logic rd_res_lo = rd_evt && (ofs_ff == idaq_pkg::OFS_RES_LO);
  wire logic wr_status = wr_evt && (ofs_ff == idaq_pkg::OFS_STATUS);
  wire logic wr_soft = wr_evt && (ofs_ff == idaq_pkg::OFS_SOFT);
  wire logic [1:0] ctl_sel = wdata_ff[7:6];

  // Pacer chain: on-board clock drives counter 2, its output clocks counter 1
  wire logic osc_tick = (osc_ff == '0);
  wire logic c2_fall = !cnt_out[2] && c2_out_q_ff;
  assign cnt_tick = {osc_tick, c2_fall, ext_clk_rise};
  assign cnt_gate = {gate_s, gate_s, 1'b1};
  // Counter 1 output is low for exactly one cycle at each expiry
  wire logic pacer_fire = !cnt_out[1];
  wire logic pacer_mode = (mode_ff == idaq_pkg::MODE_PACER_DMA) || (mode_ff == idaq_pkg::MODE_PACER_IRQ);
  wire logic soft_mode = (mode_ff == idaq_pkg::MODE_RESET);
  wire logic int_trig = (wr_soft && soft_mode) || (pacer_fire && pacer_mode);
  wire logic ext_trig = ext_sel && ext_trig_rise;
  wire logic nxt_start = ext_sel ? ext_trig : int_trig;

  // Read data mux
  logic [7:0] nxt_rdata;
  always_comb begin
    nxt_rdata = idaq_pkg::UNUSED_READ;
    if (ofs_ff == idaq_pkg::OFS_CNT0) begin
      nxt_rdata = cnt_rdata[0];
    end else if (ofs_ff == idaq_pkg::OFS_CNT1) begin
      nxt_rdata = cnt_rdata[1];
    end else if (ofs_ff == idaq_pkg::OFS_CNT2) begin
      nxt_rdata = cnt_rdata[2];
    end else if (ofs_ff == idaq_pkg::OFS_RES_LO) begin
      nxt_rdata = result_ff[7:0];
    end else if (ofs_ff == idaq_pkg::OFS_RES_HI) begin
      nxt_rdata = result_ff[15:8];
    end else if (ofs_ff == idaq_pkg::OFS_IN_LO) begin
      nxt_rdata = din_s[7:0];
    end else if (ofs_ff == idaq_pkg::OFS_IN_HI) begin
      nxt_rdata = din_s[15:8];
    end else if (ofs_ff == idaq_pkg::OFS_STATUS) begin
      nxt_rdata[idaq_pkg::PEND_BIT] = pending_ff;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_cnt
      idaq_counter #(.W(CW)) u_cnt (
        .i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_tick(cnt_tick[g]), .i_gate(cnt_gate[g]),
        .i_wr(cnt_wr[g]),
        .i_rd(cnt_rd[g]),
        .i_ctl_wr(wr_ctrl && (ctl_sel == 2'(g))),
        .i_wdata(wdata_ff), .o_rdata(cnt_rdata[g]), .o_out(cnt_out[g])
      );
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ior_q_ff <= 1'b0;
      iow_q_ff <= 1'b0;
      ext_trig_q_ff <= 1'b0;
      ext_clk_q_ff <= 1'b0;
      c2_out_q_ff <= 1'b1;
      ofs_ff <= '0;
      hit_ff <= 1'b0;
      wdata_ff <= '0;
      osc_ff <= '0;
    end else begin
      ior_q_ff <= strobe_s[1];
      iow_q_ff <= strobe_s[0];
      ext_trig_q_ff <= pin_s[3];
      ext_clk_q_ff <= pin_s[2];
      c2_out_q_ff <= cnt_out[2];
      ofs_ff <= addr_s[idaq_pkg::ADDR_W-1:0];
      hit_ff <= base_hit;
      wdata_ff <= wdata_s;
      osc_ff <= (osc_ff == '0) ? ($bits(osc_ff))'(idaq_pkg::PACER_DIV - 1) : osc_ff - 1'b1;
    end
  end

  // Conversion status, result and interrupt flag
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pending_ff <= 1'b1;
      irq_flag_ff <= 1'b0;
      result_ff <= '0;
      start_ff <= 1'b0;
    end else begin
      start_ff <= nxt_start;
      if (i_conversion_done) begin
        result_ff <= i_conversion_result_bits;
        pending_ff <= 1'b0;
      end else if (rd_res_lo) begin
        pending_ff <= 1'b1;
      end
      if (i_conversion_done && (mode_ff == idaq_pkg::MODE_PACER_IRQ)) begin
        irq_flag_ff <= 1'b1;
      end else if (wr_status) begin
        irq_flag_ff <= 1'b0;
      end
    end
  end

  // Host read data drive
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_ff <= '0;
      rd_oe_ff <= 1'b0;
    end else begin
      if (rd_evt) begin
        rdata_ff <= nxt_rdata;
        rd_oe_ff <= 1'b1;
      end else if (rd_fall) begin
        rd_oe_ff <= 1'b0;
      end
    end
  end

  // Write-only and write-side registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dout_ff <= '0;
      dac1_ff <= '0;
      dac2_ff <= '0;
      dac1_lo_ff <= '0;
      dac2_lo_ff <= '0;
      range_ff <= '0;
      chan_ff <= '0;
      mode_ff <= idaq_pkg::MODE_RESET;
    end else if (wr_evt) begin
      if (ofs_ff == idaq_pkg::OFS_RES_LO) begin
        dac1_lo_ff <= wdata_ff;
      end else if (ofs_ff == idaq_pkg::OFS_RES_HI) begin
        dac1_ff <= {wdata_ff[idaq_pkg::DAC_HI_W-1:0], dac1_lo_ff};
      end else if (ofs_ff == idaq_pkg::OFS_IN_LO) begin
        dac2_lo_ff <= wdata_ff;
      end else if (ofs_ff == idaq_pkg::OFS_IN_HI) begin
        dac2_ff <= {wdata_ff[idaq_pkg::DAC_HI_W-1:0], dac2_lo_ff};
      end else if (ofs_ff == idaq_pkg::OFS_RANGE) begin
        range_ff <= wdata_ff[idaq_pkg::RANGE_W-1:0];
      end else if (ofs_ff == idaq_pkg::OFS_CHAN) begin
        chan_ff <= wdata_ff[idaq_pkg::CHAN_W-1:0];
      end else if (ofs_ff == idaq_pkg::OFS_MODE) begin
        mode_ff <= wdata_ff[idaq_pkg::MODE_W-1:0];
      end else if (ofs_ff == idaq_pkg::OFS_OUT_LO) begin
        dout_ff[7:0] <= wdata_ff;
      end else if (ofs_ff == idaq_pkg::OFS_OUT_HI) begin
        dout_ff[15:8] <= wdata_ff;
      end
    end
  end

  assign o_io_rdata = rdata_ff;
  assign o_io_rdata_oe = rd_oe_ff;
  assign o_irq = irq_flag_ff ? (idaq_pkg::IRQ_W'(1) << IRQ_SEL) : '0;
  assign o_convert_start = start_ff;
  assign o_range = range_ff;
  assign o_channel = chan_ff;
  assign o_mode = mode_ff;
  assign o_dac1 = dac1_ff;
  assign o_dac2 = dac2_ff;
  assign o_digital_output_line = dout_ff;
  assign o_counter_output_pin = cnt_out;

  // Checks
  sequence s_low_read;
    rd_res_lo && !i_conversion_done;
  endsequence
  a_pending_set_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_low_read |=> pending_ff) else $error("pending flag not set by low byte read");
  a_pending_clear_done: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_conversion_done |=> !pending_ff) else $error("pending flag not cleared on done");
  a_status_bit_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rd_evt && ofs_ff == idaq_pkg::OFS_STATUS |=> o_io_rdata[idaq_pkg::PEND_BIT] == $past(pending_ff))
    else $error("status bit wrong");
  a_result_low_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rd_evt && ofs_ff == idaq_pkg::OFS_RES_LO |=> o_io_rdata == $past(result_ff[7:0]))
    else $error("result low byte wrong");
  a_result_high_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rd_evt && ofs_ff == idaq_pkg::OFS_RES_HI |=> o_io_rdata == $past(result_ff[15:8]))
    else $error("result high byte wrong");
  a_irq_clear_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_status && !i_conversion_done |=> o_irq == '0) else $error("interrupt not cleared");
  a_soft_trigger: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_soft && soft_mode && !ext_sel |=> o_convert_start) else $error("soft trigger lost");
  a_dout_low_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_evt && ofs_ff == idaq_pkg::OFS_OUT_LO |=> o_digital_output_line[7:0] == $past(wdata_ff))
    else $error("output low byte not latched");
  a_unused_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rd_evt && ofs_ff > idaq_pkg::OFS_STATUS |=> o_io_rdata == idaq_pkg::UNUSED_READ && $stable(pending_ff))
    else $error("unused read has effect");
endmodule

// [shared/idaq_pkg.sv]
/*
  Package for the data acquisition register decoder: offsets, field positions,
  widths, reset values and timing constants.
  Assumes a 20 MHz system clock; no other file defines these numbers.
*/
package idaq_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int BASE_W = 6;
  localparam int IO_ADDR_W = 10;
  localparam logic [BASE_W-1:0] BASE_DEFAULT = 6'h22;
  localparam logic [ADDR_W-1:0] OFS_CNT0 = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CNT1 = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CNT2 = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_RES_LO = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_RES_HI = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_IN_LO = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_IN_HI = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_RANGE = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_CHAN = 4'hA;
  localparam logic [ADDR_W-1:0] OFS_MODE = 4'hB;
  localparam logic [ADDR_W-1:0] OFS_SOFT = 4'hC;
  localparam logic [ADDR_W-1:0] OFS_OUT_LO = 4'hD;
  localparam logic [ADDR_W-1:0] OFS_OUT_HI = 4'hE;
  localparam int PEND_BIT = 5;
  localparam int DAC_W = 12;
  localparam int DAC_HI_W = 4;
  localparam int MODE_W = 3;
  localparam int RANGE_W = 2;
  localparam int CHAN_W = 6;
  localparam int IRQ_W = 16;
  localparam int IRQ_DEFAULT = 15;
  localparam logic [MODE_W-1:0] MODE_RESET = 3'h1;
  localparam logic [MODE_W-1:0] MODE_PACER_DMA = 3'h2;
  localparam logic [MODE_W-1:0] MODE_PACER_IRQ = 3'h6;
  localparam logic [DATA_W-1:0] UNUSED_READ = 8'h00;
  localparam int CLK_HZ = 20000000;
  localparam int PACER_HZ = 2000000;
  localparam int PACER_DIV = CLK_HZ / PACER_HZ;
  localparam int PACER_HALF = PACER_DIV / 2;
  localparam int CNT_W = 16;
endpackage

// [hdl/idaq_sync.sv]
/*
  Two flip-flop synchroniser, one per bit.
  Assumes its inputs are asynchronous to i_clk and are read nowhere else.
*/
`timescale 1ns/1ps
module idaq_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= i_async;
      stage2_ff <= stage1_ff;
    end
  end

  assign o_sync = stage2_ff;
endmodule

// [hdl/idaq_counter.sv]
/*
  One 16-bit down counter with byte-wide load and read, binary mode 2 style
  rate generation. Control word: bits 5:4 access (1 lsb, 2 msb, 3 lsb then msb).
  Assumes i_tick is a one-cycle pulse on i_clk and i_gate is already synchronised.
*/
`timescale 1ns/1ps
module idaq_counter #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Counting
  input wire logic i_tick,
  input wire logic i_gate,
  // Host access
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_ctl_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Output
  output logic o_out
);
  logic [W-1:0] count_ff;
  logic [W-1:0] reload_ff;
  logic [1:0] access_ff;
  logic wr_hi_ff;
  logic rd_hi_ff;
  logic armed_ff;
  logic out_ff;
  wire logic both_bytes;
  wire logic hi_now_wr;
  wire logic hi_now_rd;
  wire logic load_done;
  wire logic expire;
  wire logic [W-1:0] nxt_reload;

  assign both_bytes = (access_ff == 2'h3);
  assign hi_now_wr = (access_ff == 2'h2) || (both_bytes && wr_hi_ff);
  assign hi_now_rd = (access_ff == 2'h2) || (both_bytes && rd_hi_ff);
  assign load_done = i_wr && (!both_bytes || wr_hi_ff);
  assign nxt_reload = hi_now_wr ? {i_wdata, reload_ff[7:0]} : {reload_ff[W-1:8], i_wdata};
  assign expire = armed_ff && i_tick && i_gate && (count_ff == {{(W-1){1'b0}}, 1'b1});
  assign o_rdata = hi_now_rd ? count_ff[W-1:8] : count_ff[7:0];
  assign o_out = out_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      count_ff <= '0;
      reload_ff <= '0;
      access_ff <= 2'h3;
      wr_hi_ff <= 1'b0;
      rd_hi_ff <= 1'b0;
      armed_ff <= 1'b0;
      out_ff <= 1'b1;
    end else begin
      if (i_ctl_wr) begin
        access_ff <= (i_wdata[5:4] == 2'h0) ? access_ff : i_wdata[5:4];
        wr_hi_ff <= 1'b0;
        rd_hi_ff <= 1'b0;
        armed_ff <= 1'b0;
      end else if (i_wr) begin
        reload_ff <= nxt_reload;
        wr_hi_ff <= both_bytes && !wr_hi_ff;
      end
      if (i_rd && both_bytes) begin
        rd_hi_ff <= !rd_hi_ff;
      end
      if (load_done) begin
        count_ff <= nxt_reload;
        armed_ff <= 1'b1;
      end else if (expire) begin
        count_ff <= reload_ff;
      end else if (armed_ff && i_tick && i_gate) begin
        count_ff <= count_ff - {{(W-1){1'b0}}, 1'b1};
      end
      out_ff <= !expire;
    end
  end
endmodule

// [tb/idaq_conv_model.sv]
/*
  Behavioural A/D converter that sits behind the register decoder.
  Assumes start is a one-cycle pulse on i_clk; done follows LAT cycles later.
*/
`timescale 1ns/1ps
module idaq_conv_model #(
  parameter int LAT = 12
) (
  // Clock
  input wire logic i_clk,
  // Converter handshake
  input wire logic i_start,
  input wire logic [15:0] i_value,
  output logic o_done,
  output logic [15:0] o_result
);
  int cnt_ff = 0;
  initial o_done = 1'b0;
  // Result lines carry junk outside the done cycle
  assign o_result = o_done ? i_value : ~i_value;
  always @(posedge i_clk) begin
    o_done <= (cnt_ff == 1);
    if (i_start === 1'b1) begin
      cnt_ff <= LAT;
    end else if (cnt_ff != 0) begin
      cnt_ff <= cnt_ff - 1;
    end
  end
endmodule

// [tb/tb_isa_daq_register_decoder.sv]
/*
  Self-checking bench for the register decoder: host I/O cycles by task,
  converter model, pins driven directly.
  Assumes default base 0x220, interrupt line 15 and a 20 MHz clock.
*/
`timescale 1ns/1ps
module tb_isa_daq_register_decoder;
  typedef struct {
    logic wr;
    logic [9:0] a;
    logic [7:0] d;
    int sel;
    logic [15:0] exp;
  } idaq_row_s;
  localparam logic [9:0] BA = {idaq_pkg::BASE_DEFAULT, 4'h0};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] io_addr = 10'h000;
  logic ior_n = 1'b1;
  logic iow_n = 1'b1;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] rdata;
  logic rdata_oe;
  logic [15:0] irq;
  logic [15:0] conv_val = 16'h0000;
  logic [15:0] conv_res;
  logic conv_done;
  logic conv_start;
  logic [idaq_pkg::RANGE_W-1:0] range;
  logic [idaq_pkg::CHAN_W-1:0] chan;
  logic [idaq_pkg::MODE_W-1:0] mode;
  logic [idaq_pkg::DAC_W-1:0] dac1;
  logic [idaq_pkg::DAC_W-1:0] dac2;
  logic [15:0] di = 16'hA55A;
  logic [15:0] do_line;
  logic ext_trig = 1'b0;
  logic ext_clk = 1'b0;
  logic ext_sel = 1'b0;
  logic gate = 1'b1;
  logic seen_clr = 1'b0;
  logic [2:0] pins;
  logic [2:0] seen_low = 3'b000;
  logic [7:0] rd_d;
  logic rd_oe;
  logic [15:0] codes [4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};
  int s0;
  int n_start = 0;
  int miscompares = 0;
  int n_tests = 0;
  // Selector: 0 read data, 1 outputs, 2 range, 3 channel, 4 mode, 5/6 D/A, 7 oe
  idaq_row_s rows [17] = '{
    '{1'b1, BA + 10'd13, 8'h5A, 1, 16'h005A},
    '{1'b1, BA + 10'd14, 8'hC3, 1, 16'hC35A},
    '{1'b1, BA + 10'd9, 8'hFD, 2, 16'h0001},
    '{1'b1, BA + 10'd10, 8'hD5, 3, 16'h0015},
    '{1'b1, BA + 10'd4, 8'hBC, 5, 16'h0000},
    '{1'b1, BA + 10'd5, 8'hFA, 5, 16'h0ABC},
    '{1'b1, BA + 10'd6, 8'h21, 6, 16'h0000},
    '{1'b1, BA + 10'd7, 8'h03, 6, 16'h0321},
    '{1'b0, BA + 10'd6, 8'h00, 0, 16'h005A},
    '{1'b0, BA + 10'd7, 8'h00, 0, 16'h00A5},
    '{1'b0, BA + 10'd3, 8'h00, 0, {8'h00, idaq_pkg::UNUSED_READ}},
    '{1'b0, BA + 10'd9, 8'h00, 0, {8'h00, idaq_pkg::UNUSED_READ}},
    '{1'b0, BA + 10'd15, 8'h00, 0, {8'h00, idaq_pkg::UNUSED_READ}},
    '{1'b0, BA + 10'd16, 8'h00, 7, 16'h0000},
    '{1'b1, BA - 10'd3, 8'hFF, 1, 16'hC35A},
    '{1'b1, BA + 10'd11, 8'h02, 4, 16'h0002},
    '{1'b1, BA + 10'd11, 8'h01, 4, 16'h0001}
  };

  always #25 clk = ~clk;

  idaq_regs idaq_regs_i (
    .i_clk(clk),
    .i_rst_n(rst_n),
    .i_io_addr(io_addr),
    .i_ior_n(ior_n),
    .i_iow_n(iow_n),
    .i_io_wdata(io_wdata),
    .o_io_rdata(rdata),
    .o_io_rdata_oe(rdata_oe),
    .o_irq(irq),
    .i_conversion_result_bits(conv_res),
    .i_conversion_done(conv_done),
    .o_convert_start(conv_start),
    .o_range(range),
    .o_channel(chan),
    .o_mode(mode),
    .o_dac1(dac1),
    .o_dac2(dac2),
    .i_digital_input_line(di),
    .o_digital_output_line(do_line),
    .i_external_convert_trigger(ext_trig),
    .i_external_pacer_clock(ext_clk),
    .i_counter_gate(gate),
    .i_ext_trigger_select(ext_sel),
    .o_counter_output_pin(pins)
  );

  idaq_conv_model #(.LAT(12)) idaq_conv_model_i (
    .i_clk(clk),
    .i_start(conv_start),
    .i_value(conv_val),
    .o_done(conv_done),
    .o_result(conv_res)
  );

  always @(posedge clk) begin
    if (conv_start === 1'b1) begin
      n_start++;
    end
    if (seen_clr) begin
      seen_low <= 3'b000;
    end else if (rst_n === 1'b1) begin
      seen_low <= seen_low | ~pins;
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Address settles 3 cycles ahead; strobe low 5 cycles, high 5 after
  task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    cyc(3);
    iow_n = 1'b0;
    cyc(5);
    iow_n = 1'b1;
    cyc(5);
  endtask

  task automatic io_rd(input logic [9:0] a, output logic [7:0] d, output logic oe);
    io_addr = a;
    cyc(3);
    ior_n = 1'b0;
    cyc(5);
    d = rdata;
    oe = rdata_oe;
    ior_n = 1'b1;
    cyc(5);
  endtask

  function automatic logic [15:0] obs(input int sel);
    case (sel)
      0: return {8'h00, rd_d};
      1: return do_line;
      2: return {14'h0000, range};
      3: return {10'h000, chan};
      4: return {13'h0000, mode};
      5: return {4'h0, dac1};
      6: return {4'h0, dac2};
      default: return {15'h0000, rd_oe};
    endcase
  endfunction

  task automatic reset_chk();
    rst_n = 1'b0;
    cyc(5);
    rst_n = 1'b1;
    chk("irq reset", 16'h0000, irq);
    chk("outputs reset", 16'h0000, do_line);
    chk("mode reset", {13'h0000, idaq_pkg::MODE_RESET}, {13'h0000, mode});
    chk("pins reset", 16'h0007, {13'h0000, pins});
    chk("oe reset", 16'h0000, {15'h0000, rdata_oe});
    cyc(3);
    io_rd(BA + 10'd8, rd_d, rd_oe);
    chk("status reset", 16'h0020, {8'h00, rd_d});
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    io_rd(BA + 10'd8, rd_d, rd_oe);
    while (rd_d[idaq_pkg::PEND_BIT] !== 1'b0 && k < 20) begin
      io_rd(BA + 10'd8, rd_d, rd_oe);
      k++;
    end
    chk("status ready", 16'h0000, {8'h00, rd_d});
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end

  initial begin
    logic [7:0] hi;
    reset_chk();
    foreach (rows[r]) begin
      if (rows[r].wr) begin
        io_wr(rows[r].a, rows[r].d);
      end else begin
        io_rd(rows[r].a, rd_d, rd_oe);
      end
      chk($sformatf("row %0d", r), rows[r].exp, obs(rows[r].sel));
    end
    foreach (codes[k]) begin
      conv_val = codes[k];
      io_wr(BA + 10'd12, 8'h00);
      wait_ready();
      io_rd(BA + 10'd5, hi, rd_oe);
      io_rd(BA + 10'd4, rd_d, rd_oe);
      chk("result", codes[k], {hi, rd_d});
      io_rd(BA + 10'd8, rd_d, rd_oe);
      chk("pending again", 16'h0020, {8'h00, rd_d});
    end
    s0 = n_start;
    ext_sel = 1'b1;
    io_wr(BA + 10'd12, 8'h00);
    cyc(20);
    chk("soft blocked", 16'(s0), 16'(n_start));
    ext_trig = 1'b1;
    cyc(10);
    ext_trig = 1'b0;
    cyc(20);
    chk("ext start", 16'(s0 + 1), 16'(n_start));
    ext_sel = 1'b0;
    io_wr(BA + 10'd3, 8'h14);
    io_wr(BA, 8'h03);
    seen_clr = 1'b1;
    cyc(1);
    seen_clr = 1'b0;
    cyc(40);
    chk("cnt0 idle", 16'h0000, {15'h0000, seen_low[0]});
    repeat (6) begin
      ext_clk = 1'b1;
      cyc(4);
      ext_clk = 1'b0;
      cyc(4);
    end
    chk("cnt0 pin clock", 16'h0001, {15'h0000, seen_low[0]});
    io_rd(BA, rd_d, rd_oe);
    chk("cnt0 read", 16'h0003, {8'h00, rd_d});
    gate = 1'b0;
    io_wr(BA + 10'd11, 8'h06);
    io_wr(BA + 10'd3, 8'h94);
    io_wr(BA + 10'd2, 8'h05);
    io_wr(BA + 10'd3, 8'h54);
    io_wr(BA + 10'd1, 8'h02);
    cyc(60);
    chk("gate holds cnt2", 16'h0000, {15'h0000, seen_low[2]});
    chk("gate holds irq", 16'h0000, irq);
    gate = 1'b1;
    for (int k = 0; k < 800 && irq === 16'h0000; k++) begin
      cyc(1);
    end
    chk("irq line", 16'h8000, irq);
    chk("cnt2 out", 16'h0001, {15'h0000, seen_low[2]});
    chk("cnt1 out", 16'h0001, {15'h0000, seen_low[1]});
    io_wr(BA + 10'd11, 8'h00);
    io_wr(BA + 10'd8, 8'h00);
    chk("irq clear", 16'h0000, irq);
    reset_chk();
    stop_test();
  end
endmodule
